// File: design/fes_pkg.sv
package fes_pkg;
  // ----------------------------------------
  // controller registers
  // ----------------------------------------
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h1;
  localparam logic [3:0] REG_CMD = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_POLL = 4'h5;
  localparam logic [3:0] REG_SEQ = 4'h6;
  localparam logic [3:0] REG_SEQ_BASE = 4'h8;
  localparam int SEQ_DEPTH = 8;
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ = 1;
  localparam int CMD_RESET = 2;
  localparam int CMD_SEQ = 3;
  localparam int CMD_EWIN = 4;
  // ----------------------------------------
  // status bit positions of the device byte
  // ----------------------------------------
  localparam int BIT_POLL = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_FAIL = 5;
  localparam int BIT_WINDOW = 3;
  localparam int BIT_SECTOR = 2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_LOW_NS = 500;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_NS = 1000;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
endpackage : fes_pkg

// File: design/fes_seq_mem.sv
`timescale 1ns/1ps
`default_nettype none
module fes_seq_mem (
  input wire logic clock,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [27:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [27:0] rd_data
);
  // ----------------------------------------
  // small sequence store, registered read
  // ----------------------------------------
  logic [27:0] mem_q [0:7];
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (wr_en) begin
        mem_q[wr_idx] <= wr_data;
      end
      rd_data <= mem_q[rd_idx];
    end
  end
endmodule : fes_seq_mem
`default_nettype wire

// File: design/fes_host.sv
`timescale 1ns/1ps
`default_nettype none
module fes_host (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [19:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_in,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_strobe_n,
  output logic flash_reset_n,
  input wire logic busy_indicator_n
);
  typedef enum {ST_IDLE, ST_WSET, ST_WLOW, ST_WHOLD, ST_RLOW, ST_RDONE,
    ST_RSTLOW, ST_WAKE} fes_state_e;
  fes_state_e st_q, st_d;
  logic [19:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d, rdata_q, rdata_d, prev_q, prev_d;
  localparam int CNT_W_L = fes_pkg::CNT_W;
  logic [CNT_W_L-1:0] cnt_q, cnt_d, low_run_q, low_run_d;
  logic [2:0] seq_idx_q, seq_idx_d, seq_len_q, seq_len_d;
  logic seq_act_q, seq_act_d, ewin_q, ewin_d, ewin_chk_q, ewin_chk_d;
  logic reject_q, reject_d, toggled_q, toggled_d, read_seen_q, read_seen_d;
  logic cs_n_q, cs_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d, dqoe_n_q, dqoe_n_d, rst_n_q, rst_n_d;
  logic [31:0] rdat_q, rdat_d;
  logic [27:0] mem_rd;
  logic busy, seq_wr;
  assign busy = !busy_indicator_n;
  assign seq_wr = reg_wr && reg_addr[3];
  fes_seq_mem u_mem (
    .clock(clock),
    .clk_en(clk_en),
    .wr_en(seq_wr),
    .wr_idx(reg_addr[2:0]),
    .wr_data(reg_wdata[27:0]),
    .rd_idx(seq_idx_d),
    .rd_data(mem_rd)
  );
  // ----------------------------------------
  // bus cycle sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    prev_d = prev_q;
    cnt_d = cnt_q;
    seq_idx_d = seq_idx_q;
    seq_len_d = seq_len_q;
    seq_act_d = seq_act_q;
    ewin_d = ewin_q;
    ewin_chk_d = ewin_chk_q;
    reject_d = reject_q;
    toggled_d = toggled_q;
    read_seen_d = read_seen_q;
    cs_n_d = cs_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    dqoe_n_d = dqoe_n_q;
    rst_n_d = rst_n_q;
    low_run_d = fes_pkg::CNT_ZERO;
    if (!rst_n_q) begin
      low_run_d = low_run_q + 12'h001;
    end
    if (cnt_q != fes_pkg::CNT_ZERO) begin
      cnt_d = cnt_q - 12'h001;
    end
    if (reg_wr && reg_addr == fes_pkg::REG_ADDR) begin
      addr_d = reg_wdata[19:0];
    end
    if (reg_wr && reg_addr == fes_pkg::REG_WDATA) begin
      wdata_d = reg_wdata[7:0];
    end
    if (reg_wr && reg_addr == fes_pkg::REG_SEQ) begin
      seq_len_d = reg_wdata[2:0];
    end
    case (st_q)
      ST_IDLE: begin
        cs_n_d = 1'b1;
        we_n_d = 1'b1;
        oe_n_d = 1'b1;
        dqoe_n_d = 1'b1;
        if (seq_act_q) begin
          addr_d = mem_rd[27:8];
          wdata_d = mem_rd[7:0];
          st_d = ST_WSET;
        end else if (reg_wr && reg_addr == fes_pkg::REG_CMD) begin
          if (reg_wdata[fes_pkg::CMD_RESET]) begin
            rst_n_d = 1'b0;
            cnt_d = 12'(fes_pkg::RESET_LOW_CYC);
            st_d = ST_RSTLOW;
          end else if (reg_wdata[fes_pkg::CMD_SEQ]) begin
            seq_act_d = 1'b1;
            seq_idx_d = 3'h0;
            ewin_chk_d = reg_wdata[fes_pkg::CMD_EWIN];
            reject_d = 1'b0;
          end else if (reg_wdata[fes_pkg::CMD_WRITE]) begin
            st_d = ST_WSET;
          end else if (reg_wdata[fes_pkg::CMD_READ]) begin
            cs_n_d = 1'b0;
            oe_n_d = 1'b0;
            cnt_d = 12'(fes_pkg::STROBE_CYC);
            st_d = ST_RLOW;
          end
        end
      end
      ST_WSET: begin
        // oe held high through the write so the cycle is recognised
        cs_n_d = 1'b0;
        oe_n_d = 1'b1;
        dqoe_n_d = 1'b0;
        we_n_d = 1'b0;
        cnt_d = 12'(fes_pkg::STROBE_CYC);
        st_d = ST_WLOW;
      end
      ST_WLOW: begin
        if (cnt_q == fes_pkg::CNT_ZERO) begin
          we_n_d = 1'b1;
          cnt_d = 12'(fes_pkg::STROBE_CYC);
          st_d = ST_WHOLD;
        end
      end
      ST_WHOLD: begin
        if (cnt_q == fes_pkg::CNT_ZERO) begin
          cs_n_d = 1'b1;
          dqoe_n_d = 1'b1;
          st_d = ST_IDLE;
          if (seq_act_q) begin
            if (seq_idx_q == seq_len_q) begin
              seq_act_d = 1'b0;
              if (ewin_chk_q) begin
                // recheck window after an added sector erase
                cs_n_d = 1'b0;
                oe_n_d = 1'b0;
                cnt_d = 12'(fes_pkg::STROBE_CYC);
                st_d = ST_RLOW;
              end
            end else begin
              seq_idx_d = seq_idx_q + 3'h1;
            end
          end
        end
      end
      ST_RLOW: begin
        if (cnt_q == fes_pkg::CNT_ZERO) begin
          rdata_d = flash_dq_in;
          oe_n_d = 1'b1;
          cs_n_d = 1'b1;
          st_d = ST_RDONE;
        end
      end
      ST_RDONE: begin
        toggled_d = read_seen_q && (rdata_q[fes_pkg::BIT_TOGGLE] != prev_q[fes_pkg::BIT_TOGGLE]);
        prev_d = rdata_q;
        read_seen_d = 1'b1;
        ewin_d = rdata_q[fes_pkg::BIT_WINDOW];
        if (ewin_chk_q) begin
          reject_d = rdata_q[fes_pkg::BIT_WINDOW];
          ewin_chk_d = 1'b0;
        end
        st_d = ST_IDLE;
      end
      ST_RSTLOW: begin
        if (cnt_q == fes_pkg::CNT_ZERO) begin
          rst_n_d = 1'b1;
          read_seen_d = 1'b0;
          cnt_d = 12'(fes_pkg::WAKE_CYC);
          st_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (cnt_q == fes_pkg::CNT_ZERO) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    rdat_d = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        fes_pkg::REG_ADDR: rdat_d = {12'h000, addr_q};
        fes_pkg::REG_WDATA: rdat_d = {24'h00_0000, wdata_q};
        fes_pkg::REG_STATUS: rdat_d = {26'h000_0000, reject_q, ewin_q, toggled_q,
          seq_act_q, busy, (st_q != ST_IDLE)};
        fes_pkg::REG_RDATA: rdat_d = {24'h00_0000, rdata_q};
        fes_pkg::REG_POLL: rdat_d = {24'h00_0000, prev_q};
        fes_pkg::REG_SEQ: rdat_d = {29'h0000_0000, seq_len_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= ST_IDLE;
      addr_q <= 20'h0_0000;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      prev_q <= 8'h00;
      cnt_q <= fes_pkg::CNT_ZERO;
      seq_idx_q <= 3'h0;
      seq_len_q <= 3'h0;
      seq_act_q <= 1'b0;
      ewin_q <= 1'b0;
      ewin_chk_q <= 1'b0;
      reject_q <= 1'b0;
      toggled_q <= 1'b0;
      read_seen_q <= 1'b0;
      cs_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dqoe_n_q <= 1'b1;
      rst_n_q <= 1'b1;
      low_run_q <= fes_pkg::CNT_ZERO;
      rdat_q <= 32'h0000_0000;
    end else if (clk_en) begin
      st_q <= st_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      seq_idx_q <= seq_idx_d;
      seq_len_q <= seq_len_d;
      seq_act_q <= seq_act_d;
      ewin_q <= ewin_d;
      ewin_chk_q <= ewin_chk_d;
      reject_q <= reject_d;
      toggled_q <= toggled_d;
      read_seen_q <= read_seen_d;
      cs_n_q <= cs_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      dqoe_n_q <= dqoe_n_d;
      rst_n_q <= rst_n_d;
      low_run_q <= low_run_d;
      rdat_q <= rdat_d;
    end
  end
  assign reg_rdata = rdat_q;
  assign flash_addr = addr_q;
  assign flash_dq_out = wdata_q;
  assign flash_dq_oe_n = dqoe_n_q;
  assign chip_select_n = cs_n_q;
  assign write_strobe_n = we_n_q;
  assign output_strobe_n = oe_n_q;
  assign flash_reset_n = rst_n_q;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_rst_fall;
    $fell(flash_reset_n);
  endsequence
  sequence s_rst_low;
    !flash_reset_n [*8];
  endsequence
  a_write_oe_high: assert property (@(posedge clock) disable iff (srst)
    !write_strobe_n |-> (!chip_select_n && output_strobe_n))
    else $error("write strobe without cs low and oe high");
  a_reset_min_low: assert property (@(posedge clock) disable iff (srst)
    s_rst_fall |-> s_rst_low)
    else $error("reset pulse too short");
  // full span counted, a short pulse constant would slip past the 8-cycle check
  a_reset_len_ok: assert property (@(posedge clock) disable iff (srst)
    $rose(flash_reset_n) |-> low_run_q >= 12'(fes_pkg::RESET_LOW_CYC))
    else $error("reset low span below minimum");
  a_no_drive_rd: assert property (@(posedge clock) disable iff (srst)
    !output_strobe_n |-> flash_dq_oe_n)
    else $error("driving data while reading");
  a_wake_quiet: assert property (@(posedge clock) disable iff (srst)
    $rose(flash_reset_n) |-> output_strobe_n [*8])
    else $error("read inside wake time");
  a_reset_no_cs: assert property (@(posedge clock) disable iff (srst)
    !flash_reset_n |-> chip_select_n)
    else $error("access during reset");
endmodule : fes_host
`default_nettype wire

// File: testbench/fes_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fes_flash_model (
  input wire logic [19:0] addr,
  input wire logic [7:0] dq_drv,
  output logic [7:0] dq_in,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic rst_n,
  output logic busy_n
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic prog = 1'b0;
  logic ers = 1'b0;
  logic win = 1'b0;
  logic setup = 1'b0;
  logic tog = 1'b0;
  logic stog = 1'b0;
  logic [15:0] smask = 16'h0000;
  logic [2:0] wcnt = 3'h0;
  logic [19:0] pa = 20'h0_0000;
  logic [7:0] pd = 8'h00;
  logic [7:0] last = 8'h00;
  event go, ego;
  // pin driven low while busy or in reset, driven high otherwise
  assign busy_n = (prog || ers || !rst_n) ? 1'b0 : 1'b1;
  // released bus shows the inverse, not a stale copy
  assign dq_in = (!oe_n && !cs_n && rst_n) ? last : ~last;
  // ----------------------------------------
  // writes and reads
  // ----------------------------------------
  always @(posedge we_n) begin
    if (!cs_n && oe_n && rst_n) begin
      if (ers) begin
        // open window: one more sector joins, closed: ignored
        if (!win && dq_drv == 8'h30) begin
          smask[addr[19:16]] = 1'b1;
        end
      end else if (!prog) begin
        wcnt = wcnt + 3'h1;
        if (wcnt == 3'h3) begin
          setup = (dq_drv == 8'h80);
        end
        if (wcnt == 3'h4 && !setup) begin
          wcnt = 3'h0;
          pa = addr;
          pd = dq_drv;
          prog = 1'b1;
          ->go;
        end else if (wcnt == 3'h6) begin
          wcnt = 3'h0;
          smask = 16'h0000;
          smask[addr[19:16]] = 1'b1;
          ers = 1'b1;
          ->ego;
        end
      end
    end
  end
  // strobes fall together, so let them settle first
  always @(negedge oe_n) #1 begin
    if (!cs_n && rst_n) begin
      if (prog) begin
        tog = ~tog;
        last = {~pd[7], tog, 6'b00_0100};
      end else if (ers) begin
        tog = ~tog;
        if (smask[addr[19:16]]) begin
          stog = ~stog;
        end
        last = {1'b0, tog, 2'b00, win, stog, 2'b00};
      end else begin
        last = (addr == pa) ? pd : addr[7:0] ^ 8'h5a;
      end
    end
  end
  always @(go) begin : run
    #2000 prog = 1'b0;
  end
  always @(ego) begin : erun
    win = 1'b0;
    #600 win = 1'b1;
    #2000 ers = 1'b0;
    win = 1'b0;
  end
  always @(negedge rst_n) begin
    disable run;
    disable erun;
    prog = 1'b0;
    ers = 1'b0;
    win = 1'b0;
    wcnt = 3'h0;
  end
endmodule : fes_flash_model
`default_nettype wire

// File: testbench/flash_erase_status_and_reset_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flash_erase_status_and_reset_bench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rv;
  logic [19:0] flash_addr;
  logic [7:0] flash_dq_out, model_dq, dq_bus, t1;
  logic flash_dq_oe_n, chip_select_n, write_strobe_n, output_strobe_n;
  logic flash_reset_n, busy_indicator_n;
  int bad_count = 0;
  int checks = 0;
  always #2 clock = ~clock;
  assign dq_bus = !flash_dq_oe_n ? flash_dq_out : model_dq;
  fes_host fes_host_i (.clock(clock), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(dq_bus), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n), .flash_reset_n(flash_reset_n),
    .busy_indicator_n(busy_indicator_n));
  fes_flash_model fes_flash_model_i (.addr(flash_addr), .dq_drv(dq_bus), .dq_in(model_dq),
    .cs_n(chip_select_n), .we_n(write_strobe_n), .oe_n(output_strobe_n),
    .rst_n(flash_reset_n), .busy_n(busy_indicator_n));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    // data stand for this one cycle only, so take them mid-cycle
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask : rd
  // bounded poll: a hung engine counts as a mismatch
  task automatic wait_idle();
    logic [31:0] s;
    for (int i = 0; i < 2000; i++) begin
      rd(fes_pkg::REG_STATUS, s);
      // the engine passes through idle between sequence entries
      if (s[0] === 1'b0 && s[2] === 1'b0) return;
    end
    cmp("engine idle", 32'h0000_0000, 32'h0000_0001);
  endtask : wait_idle
  task automatic flash_read(input logic [19:0] a, output logic [31:0] d);
    wr(fes_pkg::REG_ADDR, {12'h000, a});
    wr(fes_pkg::REG_CMD, 32'h0000_0001 << fes_pkg::CMD_READ);
    wait_idle();
    rd(fes_pkg::REG_RDATA, d);
  endtask : flash_read
  task automatic program_byte(input logic [19:0] a, input logic [7:0] d);
    wr(fes_pkg::REG_SEQ_BASE, 32'h0055_55aa);
    wr(fes_pkg::REG_SEQ_BASE + 4'h1, 32'h0002_aa55);
    wr(fes_pkg::REG_SEQ_BASE + 4'h2, 32'h0055_55a0);
    wr(fes_pkg::REG_SEQ_BASE + 4'h3, {4'h0, a, d});
    wr(fes_pkg::REG_SEQ, 32'h0000_0003);
    wr(fes_pkg::REG_CMD, 32'h0000_0001 << fes_pkg::CMD_SEQ);
    wait_idle();
  endtask : program_byte
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_idle();
    rd(fes_pkg::REG_STATUS, rv);
    cmp("status busy", 32'h0000_0000, {31'h0, rv[0]});
    cmp("strobes idle", 32'h0000_000f,
      {28'h0, chip_select_n, write_strobe_n, output_strobe_n, flash_reset_n});
    flash_read(20'h0_1234, rv);
    cmp("array byte", 32'h0000_006e, {24'h0, rv[7:0]});
  endtask : t_idle
  task automatic t_program();
    program_byte(20'h0_0040, 8'h81);
    cmp("busy pin", 32'h0000_0000, {31'h0, busy_indicator_n});
    flash_read(20'h0_0040, rv);
    cmp("poll bit", 32'h0000_0000, {31'h0, rv[7]});
    t1 = rv[7:0];
    flash_read(20'h0_0040, rv);
    cmp("toggle bit", {31'h0, ~t1[6]}, {31'h0, rv[6]});
    rd(fes_pkg::REG_STATUS, rv);
    cmp("toggle seen", 32'h0000_0001, {31'h0, rv[3]});
    repeat (600) @(posedge clock);
    flash_read(20'h0_0040, rv);
    cmp("done byte", 32'h0000_0081, {24'h0, rv[7:0]});
  endtask : t_program
  task automatic t_reset_abort();
    program_byte(20'h0_0080, 8'h10);
    wr(fes_pkg::REG_CMD, 32'h0000_0001 << fes_pkg::CMD_RESET);
    wait_idle();
    cmp("busy released", 32'h0000_0001, {31'h0, busy_indicator_n});
    flash_read(20'h0_0123, rv);
    cmp("read mode", 32'h0000_0079, {24'h0, rv[7:0]});
  endtask : t_reset_abort
  task automatic t_freeze();
    wr(fes_pkg::REG_ADDR, 32'h0000_0007);
    wr(fes_pkg::REG_CMD, 32'h0000_0001 << fes_pkg::CMD_READ);
    clk_en <= 1'b0;
    repeat (40) @(posedge clock);
    cmp("frozen strobe", 32'h0000_0000, {31'h0, output_strobe_n});
    clk_en <= 1'b1;
    wait_idle();
    rd(fes_pkg::REG_RDATA, rv);
    cmp("frozen read", 32'h0000_005d, {24'h0, rv[7:0]});
  endtask : t_freeze
  task automatic add_sector(input logic [19:0] a, output logic [31:0] s);
    wr(fes_pkg::REG_SEQ_BASE, {4'h0, a, 8'h30});
    wr(fes_pkg::REG_SEQ, 32'h0000_0000);
    wr(fes_pkg::REG_CMD, (32'h0000_0001 << fes_pkg::CMD_SEQ) |
      (32'h0000_0001 << fes_pkg::CMD_EWIN));
    wait_idle();
    rd(fes_pkg::REG_STATUS, s);
  endtask : add_sector
  task automatic t_erase();
    wr(fes_pkg::REG_SEQ_BASE, 32'h0055_55aa);
    wr(fes_pkg::REG_SEQ_BASE + 4'h1, 32'h0002_aa55);
    wr(fes_pkg::REG_SEQ_BASE + 4'h2, 32'h0055_5580);
    wr(fes_pkg::REG_SEQ_BASE + 4'h3, 32'h0055_55aa);
    wr(fes_pkg::REG_SEQ_BASE + 4'h4, 32'h0002_aa55);
    wr(fes_pkg::REG_SEQ_BASE + 4'h5, 32'h0300_0030);
    wr(fes_pkg::REG_SEQ, 32'h0000_0005);
    wr(fes_pkg::REG_CMD, 32'h0000_0001 << fes_pkg::CMD_SEQ);
    wait_idle();
    add_sector(20'h5_0000, rv);
    cmp("open window bit", 32'h0000_0000, {31'h0, rv[4]});
    cmp("add accepted", 32'h0000_0000, {31'h0, rv[5]});
    flash_read(20'h5_0000, rv);
    cmp("erase poll bit", 32'h0000_0000, {31'h0, rv[7]});
    t1 = rv[7:0];
    flash_read(20'h5_0000, rv);
    cmp("erase toggle", {31'h0, ~t1[6]}, {31'h0, rv[6]});
    cmp("added sector toggle", {31'h0, ~t1[2]}, {31'h0, rv[2]});
    repeat (150) @(posedge clock);
    add_sector(20'h7_0000, rv);
    cmp("closed window bit", 32'h0000_0001, {31'h0, rv[4]});
    cmp("add rejected", 32'h0000_0001, {31'h0, rv[5]});
    flash_read(20'h7_0000, rv);
    t1 = rv[7:0];
    flash_read(20'h7_0000, rv);
    cmp("late sector steady", {31'h0, t1[2]}, {31'h0, rv[2]});
    cmp("erase busy pin", 32'h0000_0000, {31'h0, busy_indicator_n});
    repeat (700) @(posedge clock);
    cmp("erase done pin", 32'h0000_0001, {31'h0, busy_indicator_n});
    flash_read(20'h7_0000, rv);
    cmp("erased read mode", 32'h0000_005a, {24'h0, rv[7:0]});
  endtask : t_erase
  task automatic finish_test();
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_idle();
    t_freeze();
    t_program();
    t_reset_abort();
    t_erase();
    finish_test();
  end
endmodule : flash_erase_status_and_reset_bench
`default_nettype wire
